// file: core/dma_status_bank.sv
// Status-flag and operation-mode register bank of a MAC DMA engine.
// Assumes engine events arrive on aclk; software uses an AXI4-Lite master.
`timescale 1ns/100ps
`include "dma_status_params.svh"

module dma_status_bank
  import dma_status_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire dma_events_s       events,
  input  wire logic [2:0]        tx_state,
  input  wire logic [2:0]        rx_state,
  output logic [31:0]            operation_mode_control,
  output logic                   rx_suspended,
  output logic                   tx_suspended,
  output logic                   irq
);

  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_go;
  logic [31:0]       flags;
  logic [31:0]       enable;
  mitig_cfg_s        mitig;
  logic [31:0]       set_vec;
  logic [31:0]       clr_vec;
  logic [31:0]       next_flags;
  logic [31:0]       status_view;
  logic [31:0]       byte_mask;
  logic              rx_stop_prev;
  logic              tx_stop_prev;
  logic [1:0]        done_evt;
  logic [1:0]        done_fire;
  logic [3:0]        cfg_count [2];
  logic [7:0]        cfg_timer [2];

  function automatic logic [31:0] strobe_mask(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction : strobe_mask

  // Write address and data are taken independently; the write runs once
  // both are held and no response is outstanding.
  assign wr_go     = !awready && !wready && !bvalid;
  assign byte_mask = strobe_mask(wr_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      wr_addr <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready  <= 1'b1;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready  <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= 2'h0;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      case (8'(wr_addr))
        `OFS_STATUS, `OFS_MODE, `OFS_ENABLE, `OFS_CLEAR,
        `OFS_MITIGATION: bresp <= 2'h0;
        default:         bresp <= 2'h2;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Only implemented mode bits take writes; the rest hold the fixed value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operation_mode_control <= `MODE_RESET | `MODE_FIXED;
    end else if (wr_go && 8'(wr_addr) == `OFS_MODE) begin
      operation_mode_control <= (operation_mode_control
        & ~(byte_mask & `MODE_MASK))
        | (wr_data & byte_mask & `MODE_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= `ENABLE_RESET;
    end else if (wr_go && 8'(wr_addr) == `OFS_ENABLE) begin
      enable <= (enable & ~byte_mask) | (wr_data & byte_mask & `FLAG_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mitig <= `MITIG_RESET;
    end else if (wr_go && 8'(wr_addr) == `OFS_MITIGATION) begin
      mitig <= (mitig & ~byte_mask) | (wr_data & byte_mask);
    end
  end

  // Frame-done mitigation: count 0 and timer 0 passes each event at once;
  // otherwise the flag waits for the count or the timer, whichever first.
  assign done_evt     = {events.tx_frame_sent, events.rx_frame_written};
  assign cfg_count[0] = mitig.receive_mitigation_frame_count;
  assign cfg_timer[0] = mitig.receive_mitigation_timer;
  assign cfg_count[1] = mitig.transmit_mitigation_frame_count;
  assign cfg_timer[1] = mitig.transmit_mitigation_timer;

  for (genvar c = 0; c < 2; c++) begin : g_mitig
    logic [3:0] pend;
    logic [7:0] age;
    logic       by_count;
    logic       by_timer;
    assign by_count = done_evt[c] && ((cfg_count[c] == 4'h0
      && cfg_timer[c] == 8'h0) || (cfg_count[c] != 4'h0
      && ({1'b0, pend} + 5'h01) >= {1'b0, cfg_count[c]}));
    assign by_timer = pend != 4'h0 && cfg_timer[c] != 8'h0
      && age >= cfg_timer[c];
    assign done_fire[c] = by_count || by_timer;
    always_ff @(posedge aclk) begin
      if (!aresetn || done_fire[c]) begin
        pend <= 4'h0;
        age  <= 8'h0;
      end else begin
        if (done_evt[c] && pend != 4'hf) begin
          pend <= pend + 4'h1;
        end
        if ((pend != 4'h0 || done_evt[c]) && age != 8'hff) begin
          age <= age + 8'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_stop_prev <= 1'b1;
      tx_stop_prev <= 1'b1;
    end else begin
      rx_stop_prev <= events.rx_stopped_state;
      tx_stop_prev <= events.tx_stopped_state;
    end
  end

  always_comb begin
    set_vec = 32'h0;
    set_vec[`BIT_GP_TIMER]    = events.gp_timer_zero;
    set_vec[`BIT_EARLY_TX]    = events.tx_frame_in_fifo;
    set_vec[`BIT_RX_STOPPED]  = events.rx_stopped_state && !rx_stop_prev;
    set_vec[`BIT_RX_UNAVAIL]  = events.rx_desc_host_owned;
    set_vec[`BIT_RX_DONE]     = done_fire[0];
    set_vec[`BIT_TX_UNDERRUN] = events.tx_fifo_underflow;
    set_vec[`BIT_TX_UNAVAIL]  = events.tx_desc_host_owned;
    set_vec[`BIT_TX_STOPPED]  = events.tx_stopped_state & ~tx_stop_prev;
    set_vec[`BIT_TX_DONE]     = done_fire[1];
  end

  // Both the status offset and the write-only clear offset clear by ones.
  assign clr_vec = (wr_go && (8'(wr_addr) == `OFS_STATUS
    || 8'(wr_addr) == `OFS_CLEAR)) ? (wr_data & byte_mask & `FLAG_MASK)
    : 32'h0;
  assign next_flags = (flags & ~clr_vec) | set_vec;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= 32'h0;
    end else begin
      flags <= next_flags;
    end
  end

  // Suspension is set with the flag; a new descriptor problem in the same
  // cycle as a resume keeps the process suspended.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_suspended <= 1'b0;
    end else if (events.rx_desc_host_owned) begin
      rx_suspended <= 1'b1;
    end else if (events.rx_poll_demand || events.rx_frame_recognized) begin
      rx_suspended <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_suspended <= 1'b0;
    end else if (events.tx_desc_host_owned || events.tx_fifo_underflow) begin
      tx_suspended <= 1'b1;
    end else if (events.tx_poll_demand || events.tx_auto_poll) begin
      tx_suspended <= 1'b0;
    end
  end

  always_comb begin
    status_view = flags & `FLAG_MASK;
    status_view[`BIT_NORMAL] = |(flags & enable & `NORMAL_MASK);
    status_view[`BIT_ABNORMAL] = |(flags & enable & `ABNORMAL_MASK);
    status_view[`POS_RX_STATE +: 3] = rx_state;
    status_view[`POS_TX_STATE +: 3] = tx_state;
  end

  // Registered so the pin is glitch-free; it lags the flag by one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & enable & `FLAG_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= 2'h0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= 2'h0;
      case (8'(araddr))
        `OFS_STATUS:     rdata <= status_view;
        `OFS_MODE:       rdata <= operation_mode_control;
        `OFS_ENABLE:     rdata <= enable;
        `OFS_CLEAR:      rdata <= 32'h0;
        `OFS_MITIGATION: rdata <= mitig;
        default: begin
          rdata <= 32'h0;
          rresp <= 2'h2;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  property p_gp_timer;
    @(posedge aclk) disable iff (!aresetn)
    events.gp_timer_zero |=> flags[`BIT_GP_TIMER];
  endproperty
  a_gp_timer: assert property (p_gp_timer) else $error("timer flag");

  property p_early_tx;
    @(posedge aclk) disable iff (!aresetn)
    events.tx_frame_in_fifo |=> flags[`BIT_EARLY_TX];
  endproperty
  a_early_tx: assert property (p_early_tx) else $error("early flag");

  property p_rx_stop;
    @(posedge aclk) disable iff (!aresetn)
    $rose(events.rx_stopped_state) |=> flags[`BIT_RX_STOPPED];
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx stop missed");

  property p_rx_unavail;
    @(posedge aclk) disable iff (!aresetn)
    events.rx_desc_host_owned |=> flags[`BIT_RX_UNAVAIL] && rx_suspended;
  endproperty
  a_rx_unavail: assert property (p_rx_unavail) else $error("rx unavail");

  property p_rx_resume;
    @(posedge aclk) disable iff (!aresetn)
    rx_suspended && !events.rx_desc_host_owned
      && (events.rx_poll_demand || events.rx_frame_recognized)
      |=> !rx_suspended;
  endproperty
  a_rx_resume: assert property (p_rx_resume) else $error("rx no resume");

  property p_rx_done;
    @(posedge aclk) disable iff (!aresetn)
    events.rx_frame_written && mitig[11:0] == 12'h0
      |=> flags[`BIT_RX_DONE];
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("rx done missed");

  property p_rx_delay;
    @(posedge aclk) disable iff (!aresetn)
    events.rx_frame_written && mitig[3:0] == 4'h2 && mitig[11:4] == 8'h0
      && g_mitig[0].pend == 4'h0 && !flags[`BIT_RX_DONE]
      |=> !flags[`BIT_RX_DONE];
  endproperty
  a_rx_delay: assert property (p_rx_delay) else $error("rx not held");

  property p_tx_susp;
    @(posedge aclk) disable iff (!aresetn)
    events.tx_fifo_underflow |=> flags[`BIT_TX_UNDERRUN] && tx_suspended;
  endproperty
  a_tx_susp: assert property (p_tx_susp) else $error("underflow missed");

  property p_tx_unavail;
    @(posedge aclk) disable iff (!aresetn)
    events.tx_desc_host_owned |=> flags[`BIT_TX_UNAVAIL] && tx_suspended;
  endproperty
  a_tx_unavail: assert property (p_tx_unavail) else $error("tx unavail");

  property p_tx_resume;
    @(posedge aclk) disable iff (!aresetn)
    tx_suspended && !events.tx_desc_host_owned && !events.tx_fifo_underflow
      && (events.tx_poll_demand || events.tx_auto_poll) |=> !tx_suspended;
  endproperty
  a_tx_resume: assert property (p_tx_resume) else $error("tx no resume");

  property p_tx_stop;
    @(posedge aclk) disable iff (!aresetn)
    $rose(events.tx_stopped_state) |=> flags[`BIT_TX_STOPPED];
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("tx stop missed");

  property p_tx_done;
    @(posedge aclk) disable iff (!aresetn)
    events.tx_frame_sent && mitig[27:16] == 12'h0 |=> flags[`BIT_TX_DONE];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done missed");

  property p_tx_delay;
    @(posedge aclk) disable iff (!aresetn)
    events.tx_frame_sent && mitig[19:16] == 4'h2 && mitig[27:20] == 8'h0
      && g_mitig[1].pend == 4'h0 && !flags[`BIT_TX_DONE]
      |=> !flags[`BIT_TX_DONE];
  endproperty
  a_tx_delay: assert property (p_tx_delay) else $error("tx not held");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    wr_go && (8'(wr_addr) == `OFS_STATUS || 8'(wr_addr) == `OFS_CLEAR)
      && wr_strb[0] && wr_data[0] && !set_vec[0] |=> !flags[0];
  endproperty
  a_clear: assert property (p_clear) else $error("w1c failed");

  property p_keep;
    @(posedge aclk) disable iff (!aresetn)
    flags[`BIT_GP_TIMER] && !(wr_go && wr_data[`BIT_GP_TIMER])
      |=> flags[`BIT_GP_TIMER];
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost");

  property p_fixed;
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready && 8'(araddr) == `OFS_MODE
      |=> (rdata & ~`MODE_MASK) == `MODE_FIXED;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits moved");

  property p_summary;
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready && 8'(araddr) == `OFS_STATUS
      |=> rdata[`BIT_NORMAL] == |($past(flags & enable) & `NORMAL_MASK);
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
    set_vec[`BIT_TX_DONE] && clr_vec[`BIT_TX_DONE] |=> flags[`BIT_TX_DONE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost");

  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_mitig: cover property (@(posedge aclk) disable iff (!aresetn)
    g_mitig[0].by_timer);
  c_resume: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(tx_suspended));
  c_race: cover property (@(posedge aclk) disable iff (!aresetn)
    |(set_vec & clr_vec));

endmodule : dma_status_bank

// file: core/dma_status_params.svh
// Offsets, field positions, reset values and masks of the DMA status bank.
// Assumes inclusion by the register bank module only.
`ifndef DMA_STATUS_PARAMS_SVH
`define DMA_STATUS_PARAMS_SVH

`define OFS_STATUS      8'h00
`define OFS_MODE        8'h04
`define OFS_ENABLE      8'h08
`define OFS_CLEAR       8'h0c
`define OFS_MITIGATION  8'h10

`define BIT_TX_DONE     0
`define BIT_TX_STOPPED  1
`define BIT_TX_UNAVAIL  2
`define BIT_TX_UNDERRUN 5
`define BIT_RX_DONE     6
`define BIT_RX_UNAVAIL  7
`define BIT_RX_STOPPED  8
`define BIT_EARLY_TX    10
`define BIT_GP_TIMER    11
`define BIT_ABNORMAL    15
`define BIT_NORMAL      16
`define POS_RX_STATE    17
`define POS_TX_STATE    20

`define FLAG_MASK       32'h0000_0de7
`define NORMAL_MASK     32'h0000_0845
`define ABNORMAL_MASK   32'h0000_05a2
`define MODE_MASK       32'h4060_e2df
`define MODE_FIXED      32'h0000_0000
`define MODE_RESET      32'h0000_0000
`define ENABLE_RESET    32'h0000_0000
`define MITIG_RESET     32'h0000_0000

`endif

// file: core/dma_status_pkg.sv
// Types shared by the DMA status bank and its surroundings.
// Assumes the constants header is on the include path.
package dma_status_pkg;

  // One-cycle event pulses and levels from the transmit and receive engines.
  typedef struct packed {
    logic gp_timer_zero;
    logic tx_frame_in_fifo;
    logic rx_stopped_state;
    logic rx_desc_host_owned;
    logic rx_frame_written;
    logic tx_fifo_underflow;
    logic tx_desc_host_owned;
    logic tx_stopped_state;
    logic tx_frame_sent;
    logic rx_poll_demand;
    logic rx_frame_recognized;
    logic tx_poll_demand;
    logic tx_auto_poll;
  } dma_events_s;

  typedef struct packed {
    logic [3:0] unused_hi;
    logic [7:0] transmit_mitigation_timer;
    logic [3:0] transmit_mitigation_frame_count;
    logic [3:0] unused_lo;
    logic [7:0] receive_mitigation_timer;
    logic [3:0] receive_mitigation_frame_count;
  } mitig_cfg_s;

endpackage : dma_status_pkg

// file: testbench/tb.sv
// Self-checking bench for the DMA status and mode register bank.
// Assumes the bank alone on one 20 MHz clock, driven over AXI4-Lite.
`timescale 1ns/100ps

module tb
  import dma_status_pkg::*;
;

  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  dma_events_s ev;
  logic [2:0]  tx_state;
  logic [2:0]  rx_state;
  logic [31:0] mode_out;
  logic        rx_suspended;
  logic        tx_suspended;
  logic        irq;
  int          num_errors;
  int          checks;
  logic [31:0] base;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          ev_idx[9] = '{12, 11, 10, 9, 8, 7, 6, 5, 4};
  int          fbit[9]   = '{11, 10, 8, 7, 6, 5, 2, 1, 0};

  dma_status_bank u_dut (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .awaddr                 (awaddr),
    .awvalid                (awvalid),
    .awready                (awready),
    .wdata                  (wdata),
    .wstrb                  (wstrb),
    .wvalid                 (wvalid),
    .wready                 (wready),
    .bresp                  (bresp),
    .bvalid                 (bvalid),
    .bready                 (bready),
    .araddr                 (araddr),
    .arvalid                (arvalid),
    .arready                (arready),
    .rdata                  (rdata),
    .rresp                  (rresp),
    .rvalid                 (rvalid),
    .rready                 (rready),
    .events                 (ev),
    .tx_state               (tx_state),
    .rx_state               (rx_state),
    .operation_mode_control (mode_out),
    .rx_suspended           (rx_suspended),
    .tx_suspended           (tx_suspended),
    .irq                    (irq)
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic final_report;
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Address and data are offered together and each is dropped once taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic read_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
    axi_read(a, rd, rs);
    chk(nm, exp, rd);
    chk("rresp", 32'h0, {30'h0, rs});
  endtask : read_chk

  task automatic pulse(input int idx);
    @(posedge aclk);
    ev <= dma_events_s'(13'h1 << idx);
    @(posedge aclk);
    ev <= '0;
  endtask : pulse

  task automatic susp_chk(input int idx, input logic rx, input logic tx);
    pulse(idx);
    cyc(2);
    chk("rx_suspended", {31'h0, rx}, {31'h0, rx_suspended});
    chk("tx_suspended", {31'h0, tx}, {31'h0, tx_suspended});
  endtask : susp_chk

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    final_report();
  end

  initial begin
    aresetn  = 1'b0;
    awaddr   = 8'h00;
    awvalid  = 1'b0;
    wdata    = 32'h0;
    wstrb    = 4'hf;
    wvalid   = 1'b0;
    bready   = 1'b0;
    araddr   = 8'h00;
    arvalid  = 1'b0;
    rready   = 1'b0;
    ev       = '0;
    tx_state = 3'h5;
    rx_state = 3'h3;
    base     = {9'h0, 3'h5, 3'h3, 17'h0};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    read_chk("status", 8'h00, base);
    read_chk("mode", 8'h04, 32'h0);
    read_chk("enable", 8'h08, 32'h0);
    read_chk("clear", 8'h0c, 32'h0);
    axi_write(8'h04, 32'hffff_ffff, 2'b00);
    read_chk("mode", 8'h04, 32'h4060_e2df);
    chk("mode_port", 32'h4060_e2df, mode_out);
    wstrb <= 4'h1;
    axi_write(8'h04, 32'h0, 2'b00);
    wstrb <= 4'hf;
    read_chk("mode_strb", 8'h04, 32'h4060_e200);
    axi_write(8'h04, 32'h0, 2'b00);
    // Odd passes clear through the status word, even ones via the clear word.
    for (int i = 0; i < 9; i++) begin
      pulse(ev_idx[i]);
      read_chk("flag_set", 8'h00, base | (32'h1 << fbit[i]));
      axi_write(8'h00, ~(32'h1 << fbit[i]), 2'b00);
      read_chk("flag_hold", 8'h00, base | (32'h1 << fbit[i]));
      chk("irq_masked", 32'h0, {31'h0, irq});
      axi_write((i % 2) ? 8'h00 : 8'h0c, 32'h1 << fbit[i], 2'b00);
      read_chk("flag_clr", 8'h00, base);
    end
    susp_chk(3, 1'b0, 1'b1);
    susp_chk(9, 1'b1, 1'b1);
    susp_chk(2, 1'b0, 1'b1);
    susp_chk(1, 1'b0, 1'b0);
    susp_chk(7, 1'b0, 1'b1);
    susp_chk(0, 1'b0, 1'b0);
    susp_chk(6, 1'b0, 1'b1);
    susp_chk(1, 1'b0, 1'b0);
    axi_write(8'h0c, 32'h0000_0de7, 2'b00);
    axi_write(8'h08, 32'h0000_0001, 2'b00);
    pulse(4);
    pulse(7);
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq});
    read_chk("normal_sum", 8'h00, base | 32'h0001_0021);
    axi_write(8'h08, 32'h0000_0020, 2'b00);
    read_chk("abnormal_sum", 8'h00, base | 32'h0000_8021);
    axi_write(8'h0c, 32'h0000_0de7, 2'b00);
    cyc(2);
    chk("irq_clr", 32'h0, {31'h0, irq});
    // The event lands in the very cycle whose edge applies the clear.
    fork
      axi_write(8'h0c, 32'h0000_0001, 2'b00);
      begin
        cyc(2);
        ev <= dma_events_s'(13'h1 << 4);
        @(posedge aclk);
        ev <= '0;
      end
    join
    read_chk("set_wins", 8'h00, base | 32'h0000_0001);
    axi_write(8'h00, 32'h0000_0001, 2'b00);
    axi_write(8'h10, 32'h0000_0002, 2'b00);
    pulse(8);
    read_chk("mitig_held", 8'h00, base);
    pulse(8);
    read_chk("mitig_fire", 8'h00, base | 32'h0000_0040);
    axi_write(8'h10, 32'h0002_0000, 2'b00);
    pulse(4);
    read_chk("mitig_tx_held", 8'h00, base | 32'h0000_0040);
    pulse(4);
    read_chk("mitig_tx_fire", 8'h00, base | 32'h0000_0041);
    // A lone frame with a timer of four cycles only shows once the timer ends.
    axi_write(8'h00, 32'h0000_0041, 2'b00);
    axi_write(8'h10, 32'h0000_0040, 2'b00);
    pulse(8);
    read_chk("mitig_tmr_held", 8'h00, base);
    read_chk("mitig_tmr_fire", 8'h00, base | 32'h0000_0040);
    axi_write(8'h14, 32'hffff_ffff, 2'b10);
    axi_read(8'h14, rd, rs);
    chk("unmapped_data", 32'h0, rd);
    chk("unmapped_resp", 32'h2, {30'h0, rs});
    final_report();
  end

endmodule : tb
